// ### rtl/rsw_map.svh
// Purpose: Timing constants for the reset supervisor and watchdog
// Assumes: 125 MHz clock_i; all long times counted in time-base ticks
// Notes:   Counts in ticks are 32-bit expressions; cast at the point of use
`ifndef RSW_MAP_SVH
`define RSW_MAP_SVH

`define RSW_CLK_NS          8
`define RSW_TICK_NS         500000
`define RSW_TICK_CYC        (`RSW_TICK_NS / `RSW_CLK_NS)
`define RSW_TICK_W          17
`define RSW_RST_MIN_US      250000
`define RSW_DEBOUNCE_US     20000
`define RSW_WD_SHORT_US     150000
`define RSW_WD_MID_US       600000
`define RSW_WD_LONG_US      1200000
// One extra tick covers the partial tick at the moment of loading
`define RSW_STRETCH_TICKS   (`RSW_RST_MIN_US * 1000 / `RSW_TICK_NS + 1)
`define RSW_DEBOUNCE_TICKS  (`RSW_DEBOUNCE_US * 1000 / `RSW_TICK_NS)
`define RSW_WD_SHORT_TICKS  (`RSW_WD_SHORT_US * 1000 / `RSW_TICK_NS)
`define RSW_WD_MID_TICKS    (`RSW_WD_MID_US * 1000 / `RSW_TICK_NS)
`define RSW_WD_LONG_TICKS   (`RSW_WD_LONG_US * 1000 / `RSW_TICK_NS)
`define RSW_STRETCH_W       10
`define RSW_DEBOUNCE_W      6
`define RSW_WD_W            12

`endif

// ### rtl/rsw_pkg.sv
// Purpose: Types for the reset supervisor and watchdog
// Assumes: Three-level select pin arrives already encoded on two bits
// Notes:   Code 2'b11 is not a legal pin state and is treated as tied high
package rsw_pkg;
    typedef enum logic [1:0] {
        RSW_TSEL_LOW   = 2'b00,
        RSW_TSEL_FLOAT = 2'b01,
        RSW_TSEL_HIGH  = 2'b10
    } rsw_tsel_t;
endpackage

// ### rtl/rsw_top.sv
// Purpose: Reset supervisor with power-fail, pushbutton and watchdog sources
// Assumes: Pin inputs are asynchronous and pass two flip-flops first
// Notes:   All long times come from one 0.5 ms tick; TICK_CYC may be shortened
// Operation
// R01 - Power-fail indication forces both reset outputs active.
// R02 - After supply recovers or power-up, hold reset at least 250 ms.
// R03 - Tolerance select chooses the 2.98 V or 2.64 V fail threshold.
// R04 - Pushbutton input is active low; outside pulls it low to reset.
// R05 - Debounce pushbutton; accepted press gives reset of at least 250 ms.
// R06 - Pushbutton stretch interval starts when the button is released.
// R07 - Reset asserts when strobe is not toggled within the timeout.
// R08 - Timeout select gives minimum 62.5, 250 or 500 ms.
// R09 - Nominal timeouts are about 150 ms, 600 ms and 1.2 s.
// R10 - Watchdog counts only while both reset outputs are inactive.
// R11 - Strobe falling edge before timeout clears the watchdog counter.
// R12 - Watchdog timeout asserts reset for at least 250 ms.
// R13 - Processor strobes no slower than the minimum selected timeout.
// R14 - Watchdog cannot be disabled; no strobes always means reset.
// R15 - Two reset outputs: active high and its active-low complement.
// R16 - One shared stretch counter; reassertion restarts the interval.
// R17 - All intervals come from one time base, sized for longest timeout.
`include "rsw_map.svh"

module rsw_top #(
    parameter int TICK_CYC = `RSW_TICK_CYC
) (
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    input  wire logic              power_fail_2v98_i,
    input  wire logic              power_fail_2v64_i,
    input  wire logic              tolerance_select_i,
    input  wire rsw_pkg::rsw_tsel_t timeout_select_i,
    input  wire logic              pushbutton_reset_n_i,
    input  wire logic              watchdog_strobe_n_i,
    output logic                   reset_o,
    output logic                   reset_n_o
);
    import rsw_pkg::*;

    localparam logic [`RSW_STRETCH_W-1:0]  STRETCH_LOAD = `RSW_STRETCH_W'(`RSW_STRETCH_TICKS);
    localparam logic [`RSW_DEBOUNCE_W-1:0] DEB_LIMIT    = `RSW_DEBOUNCE_W'(`RSW_DEBOUNCE_TICKS);
    localparam logic [`RSW_TICK_W-1:0]     TICK_LAST    = `RSW_TICK_W'(TICK_CYC - 1);

    // Timeout in ticks for each select setting, nominal figures
    function automatic logic [`RSW_WD_W-1:0] wd_limit_f(input rsw_tsel_t sel);
        case (sel)
            RSW_TSEL_LOW:   wd_limit_f = `RSW_WD_W'(`RSW_WD_SHORT_TICKS); // [R08] [R09]
            RSW_TSEL_FLOAT: wd_limit_f = `RSW_WD_W'(`RSW_WD_MID_TICKS);   // [R08] [R09]
            default:        wd_limit_f = `RSW_WD_W'(`RSW_WD_LONG_TICKS);  // [R08] [R09]
        endcase
    endfunction

    // Two-stage synchronisers; stage one feeds only stage two
    logic [6:0] sync1_r;
    logic [6:0] sync2_r;
    logic       strobe_d_r;
    always_ff @(posedge clock_i) begin
        sync1_r    <= {timeout_select_i, tolerance_select_i, power_fail_2v98_i,
                       power_fail_2v64_i, pushbutton_reset_n_i, watchdog_strobe_n_i};
        sync2_r    <= sync1_r;
        strobe_d_r <= sync2_r[0];
    end

    wire       strobe_s  = sync2_r[0];
    wire       pb_n_s    = sync2_r[1];
    wire       pf_lo_s   = sync2_r[2];
    wire       pf_hi_s   = sync2_r[3];
    wire       tol_s     = sync2_r[4];
    rsw_tsel_t tsel_s;
    assign tsel_s = rsw_tsel_t'(sync2_r[6:5]);

    // Tied low watches the higher threshold, tied high the lower one
    wire pf_s        = tol_s ? pf_lo_s : pf_hi_s;           // [R03]
    wire strobe_fall = strobe_d_r & ~strobe_s;              // [R11]

    // Free-running time base shared by every interval
    logic [`RSW_TICK_W-1:0] tick_cnt_r;
    wire tick = (tick_cnt_r == TICK_LAST);                  // [R17]
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + `RSW_TICK_W'(1);
        end
    end

    // Debounce: press accepted only after staying low a full debounce time
    logic [`RSW_DEBOUNCE_W-1:0] deb_cnt_r;
    logic                       pb_held_r;
    wire deb_done = (deb_cnt_r == DEB_LIMIT);
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || pb_n_s) begin                       // [R04]
            deb_cnt_r <= '0;
            pb_held_r <= 1'b0;
        end else begin
            if (tick && !deb_done) begin
                deb_cnt_r <= deb_cnt_r + `RSW_DEBOUNCE_W'(1);
            end
            pb_held_r <= pb_held_r | deb_done;              // [R05]
        end
    end

    // Watchdog counter; runs only while reset is released
    logic [`RSW_WD_W-1:0] wd_cnt_r;
    logic                 reset_r;
    wire [`RSW_WD_W-1:0] wd_limit = wd_limit_f(tsel_s);
    wire wd_expire = ~reset_r & (wd_cnt_r >= wd_limit);     // [R07] [R14]
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || reset_r || strobe_fall) begin       // [R10] [R11]
            wd_cnt_r <= '0;
        end else if (tick && !wd_expire) begin
            wd_cnt_r <= wd_cnt_r + `RSW_WD_W'(1);
        end
    end

    // Shared stretch: any live source reloads, so the interval restarts
    logic [`RSW_STRETCH_W-1:0] stretch_cnt_r;
    wire hold    = pf_s | pb_held_r;                        // [R01] [R06]
    wire reload  = hold | wd_expire;                        // [R16] [R12]
    wire running = (stretch_cnt_r != '0);
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || reload) begin                       // [R02]
            stretch_cnt_r <= STRETCH_LOAD;
        end else if (tick && running) begin
            stretch_cnt_r <= stretch_cnt_r - `RSW_STRETCH_W'(1);
        end
    end

    // Outputs straight from one flop pair so they never disagree
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            reset_r   <= 1'b1;
            reset_n_o <= 1'b0;
        end else begin
            reset_r   <= reload | running;                  // [R15]
            reset_n_o <= ~(reload | running);               // [R15]
        end
    end
    assign reset_o = reset_r;

    // Checks below share one clock and are silent while rst_n_i is low.
    // They watch internal state as well as pins, so a failure points
    // at the counter or flag that went wrong, not only at the outputs.
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_pb_release;
        pb_held_r ##1 pb_n_s;
    endsequence

    property p_pf_forces;
        pf_s |=> reset_o ##0 !reset_n_o;
    endproperty
    a_pf_forces: assert property (p_pf_forces) else $error("power fail did not force reset"); // [R01]

    property p_pf_stretch;
        $fell(pf_s) && !pb_held_r |-> reset_o [*8];
    endproperty
    a_pf_stretch: assert property (p_pf_stretch) else $error("reset dropped after recovery"); // [R02]

    property p_tol_select;
        !tol_s && pf_hi_s |=> stretch_cnt_r == STRETCH_LOAD;
    endproperty
    a_tol_select: assert property (p_tol_select) else $error("threshold select ignored"); // [R03]

    property p_pb_accept;
        deb_done && !pb_n_s |=> pb_held_r ##1 reset_o;
    endproperty
    a_pb_accept: assert property (p_pb_accept) else $error("accepted press gave no reset"); // [R04] [R05]

    property p_pb_release;
        s_pb_release |-> stretch_cnt_r == STRETCH_LOAD ##1 reset_o;
    endproperty
    a_pb_release: assert property (p_pb_release) else $error("stretch not from release"); // [R06]

    property p_wd_frozen;
        reset_r |=> wd_cnt_r == '0;
    endproperty
    a_wd_frozen: assert property (p_wd_frozen) else $error("watchdog ran during reset"); // [R10]

    property p_strobe_clear;
        strobe_fall |=> wd_cnt_r == '0;
    endproperty
    a_strobe_clear: assert property (p_strobe_clear) else $error("strobe did not clear watchdog"); // [R11]

    property p_wd_reset;
        wd_expire |=> reset_o && stretch_cnt_r == STRETCH_LOAD;
    endproperty
    a_wd_reset: assert property (p_wd_reset) else $error("timeout gave no stretched reset"); // [R07] [R12]

    // A select change to a shorter limit may leave the count above it for
    // the cycle that raises reset and the cycle that clears the count
    property p_no_disable;
        wd_cnt_r <= wd_limit || $changed(tsel_s) || reset_r || $past(reset_r);
    endproperty
    a_no_disable: assert property (p_no_disable) else $error("watchdog passed its limit"); // [R14]

    property p_outs_pair;
        reset_o == !reset_n_o;
    endproperty
    a_outs_pair: assert property (p_outs_pair) else $error("reset outputs disagree"); // [R15]

    property p_tick_only;
        running && !reload && !tick |=> $stable(stretch_cnt_r);
    endproperty
    a_tick_only: assert property (p_tick_only) else $error("stretch moved off tick"); // [R16] [R17]

    // A source that returns mid-stretch starts the full interval again
    property p_reassert;
        running && reload |=> stretch_cnt_r == STRETCH_LOAD && reset_o;
    endproperty
    a_reassert: assert property (p_reassert) else $error("reassertion did not restart stretch"); // [R16]

    // The time base wraps right after its last count
    property p_tick_wrap;
        tick |=> tick_cnt_r == '0;
    endproperty
    a_tick_wrap: assert property (p_tick_wrap) else $error("time base did not wrap"); // [R17]

    // A released button drops any partial debounce count at once
    property p_deb_reject;
        pb_n_s |=> !pb_held_r && deb_cnt_r == '0;
    endproperty
    a_deb_reject: assert property (p_deb_reject) else $error("bounce kept debounce state"); // [R05]
endmodule

// ### tb/rsw_cpu_model.sv
// Purpose: Processor-side strobe source for the supervisor bench
// Assumes: Strobe period is given in clock cycles
// Notes:   Strobe idles high; the line is always driven, never released
module rsw_cpu_model (
    input  wire logic        clock_i,
    input  wire logic        enable_i,
    input  wire logic [15:0] period_i,
    output logic             strobe_n_o
);
    logic [15:0] cnt_r = 16'h0000;
    initial strobe_n_o = 1'b1;
    // Four-cycle low pulse each period, kept under the shortest timeout
    always @(posedge clock_i) begin
        cnt_r <= (!enable_i || cnt_r >= period_i) ? 16'h0000 : cnt_r + 16'h0001;
        strobe_n_o <= !(enable_i && cnt_r < 16'h0004);
    end
endmodule

// ### tb/reset_supervisor_watchdog_tb_top.sv
// Purpose: Self-checking bench for the reset supervisor and watchdog
// Assumes: Short time base of 4 cycles a tick; counts in ticks unchanged
// Notes:   Reset timing is judged by cycle counts with up to three ticks of slack
module reset_supervisor_watchdog_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rsw_pkg::*;
    localparam int TC = 4;
    logic      clock = 1'b0;
    logic      rst_n = 1'b0;
    logic      pf98  = 1'b0;
    logic      pf64  = 1'b0;
    logic      tolerance_select   = 1'b0;
    rsw_tsel_t tsel  = RSW_TSEL_LOW;
    logic      pb_n  = 1'b1;
    logic      cpu_en = 1'b1;
    logic      strobe_n;
    logic      reset;
    logic      reset_n;
    int        n_errors = 0;
    int        check_count = 0;
    int        n;
    always #4 clock = ~clock;
    rsw_top #(.TICK_CYC(TC)) rsw_top_i (.clock_i(clock), .rst_n_i(rst_n),
        .power_fail_2v98_i(pf98), .power_fail_2v64_i(pf64), .tolerance_select_i(tolerance_select),
        .timeout_select_i(tsel), .pushbutton_reset_n_i(pb_n),
        .watchdog_strobe_n_i(strobe_n), .reset_o(reset), .reset_n_o(reset_n));
    rsw_cpu_model rsw_cpu_model_i (.clock_i(clock), .enable_i(cpu_en),
        .period_i(16'h01c0), .strobe_n_o(strobe_n));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int v, input int lo, input int hi);
        check_count++;
        if (v < lo || v > hi) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
        end
    endtask
    // Count cycles until reset reaches lvl; both outputs must agree
    task automatic wait_rst(input logic lvl, input int lim);
        n = 0;
        while (reset !== lvl && n < lim) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk({30'h0, reset, reset_n}, {30'h0, lvl, ~lvl});
    endtask
    task automatic t_power();
        @(posedge clock) pf98 <= 1'b1;
        wait_rst(1'b1, 6);
        repeat (50) @(posedge clock);
        pf98 <= 1'b0;
        wait_rst(1'b0, 2100);
        chk_rng(n, 2000, 2012);
        @(posedge clock) tolerance_select <= 1'b1;
        pf98 <= 1'b1;
        repeat (100) @(posedge clock);
        chk(reset, 1'b0);
        pf64 <= 1'b1;
        wait_rst(1'b1, 6);
        @(posedge clock) pf64 <= 1'b0;
        pf98 <= 1'b0;
        repeat (1000) @(posedge clock);
        pf64 <= 1'b1;
        repeat (10) @(posedge clock);
        pf64 <= 1'b0;
        wait_rst(1'b0, 2100);
        chk_rng(n, 2000, 2012);
    endtask
    task automatic t_watchdog(input rsw_tsel_t s, input int lim);
        @(posedge clock) tsel <= s;
        repeat (6000) @(posedge clock);
        chk(reset, 1'b0);
        cpu_en <= 1'b0;
        wait_rst(1'b1, lim * TC + 20);
        wait_rst(1'b0, 2100);
        chk_rng(n, 2000, 2012);
        wait_rst(1'b1, lim * TC + 20);
        chk_rng(n, lim * TC - 8, lim * TC + 8);
        @(posedge clock) cpu_en <= 1'b1;
        wait_rst(1'b0, 2100);
    endtask
    task automatic t_button();
        @(posedge clock) pb_n <= 1'b0;
        repeat (100) @(posedge clock);
        pb_n <= 1'b1;
        repeat (300) @(posedge clock);
        chk(reset, 1'b0);
        pb_n <= 1'b0;
        wait_rst(1'b1, 200);
        chk_rng(n, 152, 172);
        repeat (2500) @(posedge clock);
        pb_n <= 1'b1;
        wait_rst(1'b0, 2100);
        chk_rng(n, 2000, 2012);
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Cuts a hang short; normal run is about 70,000 cycles
    initial begin
        #1000000;
        n_errors++;
        print_verdict();
    end
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        wait_rst(1'b0, 2100);
        chk_rng(n, 2000, 2012);
        t_power();
        t_watchdog(RSW_TSEL_LOW, 300);
        t_watchdog(RSW_TSEL_FLOAT, 1200);
        t_watchdog(RSW_TSEL_HIGH, 2400);
        t_button();
        print_verdict();
    end
endmodule
